// [pdp_pkg.sv]
// constants, register map and address decode for the port direction, data and pull-up register set
//
// How it works
// R1: port B direction bits: 0 input, 1 output; write-only, reset zero.
// R2: port B data register, eight bits, read and write, reset zero.
// R3: port A data register, eight bits, read and write, reset zero.
// R4: port 4 pull-up bits: 0 off, 1 on; read and write, reset zero.
// R5: port 4 pull-up acts only while its direction bit selects input.
// R6: port 2 pull-up acts only while its direction bit selects input.
// R7: port 5 pull-up acts only while its direction bit selects input.
// R8: port 7 data read returns live pin levels; writes ignored; no reset value. Here the two synchroniser flops reset to zero.
package pdp_pkg;

    // ------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_PORT8_DIRECTION      = 10'h0cd;
    localparam logic [9:0] IDX_PORT7_PIN_LEVELS     = 10'h0ce;
    localparam logic [9:0] IDX_PORT8_OUTPUT_DATA    = 10'h0cf;
    localparam logic [9:0] IDX_PORT2_DIRECTION      = 10'h0d0;
    localparam logic [9:0] IDX_PORT4_DIRECTION      = 10'h0d1;
    localparam logic [9:0] IDX_PORT5_DIRECTION      = 10'h0d2;
    localparam logic [9:0] IDX_PORTA_OUTPUT_DATA    = 10'h0d3;
    localparam logic [9:0] IDX_PORTB_DIRECTION      = 10'h0d4;
    localparam logic [9:0] IDX_PORTB_OUTPUT_DATA    = 10'h0d6;
    localparam logic [9:0] IDX_PORT2_PULLUP_CONTROL = 10'h0d8;
    localparam logic [9:0] IDX_PORT5_PULLUP_CONTROL = 10'h0d9;
    localparam logic [9:0] IDX_PORT4_PULLUP_CONTROL = 10'h0da;

    // ------------------------------------------------------------
    // widths and values after reset
    // ------------------------------------------------------------
    localparam int         ADDR_W      = 12;
    localparam logic [7:0] RST_BYTE    = 8'h00;
    localparam logic [4:0] RST_PORT8   = 5'h00;
    localparam logic [3:0] RST_PORT5   = 4'h0;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        SEL_NONE,
        SEL_P8_DIR,
        SEL_P8_DATA,
        SEL_P7_PINS,
        SEL_P2_DIR,
        SEL_P4_DIR,
        SEL_P5_DIR,
        SEL_PA_DATA,
        SEL_PB_DIR,
        SEL_PB_DATA,
        SEL_P2_PU,
        SEL_P5_PU,
        SEL_P4_PU
    } pdp_sel_e;

    function automatic pdp_sel_e pdp_decode(input logic [ADDR_W-1:0] addr);
        pdp_sel_e sel;
        sel = SEL_NONE;
        case (addr[ADDR_W-1:2])
            IDX_PORT8_DIRECTION:      sel = SEL_P8_DIR;
            IDX_PORT7_PIN_LEVELS:     sel = SEL_P7_PINS;
            IDX_PORT8_OUTPUT_DATA:    sel = SEL_P8_DATA;
            IDX_PORT2_DIRECTION:      sel = SEL_P2_DIR;
            IDX_PORT4_DIRECTION:      sel = SEL_P4_DIR;
            IDX_PORT5_DIRECTION:      sel = SEL_P5_DIR;
            IDX_PORTA_OUTPUT_DATA:    sel = SEL_PA_DATA;
            IDX_PORTB_DIRECTION:      sel = SEL_PB_DIR;
            IDX_PORTB_OUTPUT_DATA:    sel = SEL_PB_DATA;
            IDX_PORT2_PULLUP_CONTROL: sel = SEL_P2_PU;
            IDX_PORT5_PULLUP_CONTROL: sel = SEL_P5_PU;
            IDX_PORT4_PULLUP_CONTROL: sel = SEL_P4_PU;
            default:                  sel = SEL_NONE;
        endcase
        return sel;
    endfunction

endpackage

// [pdp_sync.sv]
// two-flop synchroniser for asynchronous pin levels
module pdp_sync
    import pdp_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input  wire logic             clk_sys_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } pdp_sync_s;

    pdp_sync_s state_reg;
    pdp_sync_s state_next;

    // the first stage feeds only the second stage
    always_comb
    begin
        state_next.meta   = async_i;
        state_next.stable = state_reg.meta;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign sync_o = state_reg.stable;

endmodule

// [pdp_regs.sv]
// port direction, data and pull-up register set behind an axi4-lite slave
module pdp_regs
    import pdp_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    input  wire logic [7:0]        port7_pins_i,
    output logic [7:0]             porta_data_o,
    output logic [7:0]             portb_data_o,
    output logic [7:0]             portb_oe_o,
    output logic [4:0]             port8_data_o,
    output logic [4:0]             port8_oe_o,
    output logic [7:0]             port2_oe_o,
    output logic [7:0]             port4_oe_o,
    output logic [3:0]             port5_oe_o,
    output logic [7:0]             port2_pullup_o,
    output logic [7:0]             port4_pullup_o,
    output logic [3:0]             port5_pullup_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic              aw_full;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_full;
        logic [7:0]        w_byte;
        logic              w_en;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [7:0]        rdata;
        logic [4:0]        p8_dir;
        logic [4:0]        p8_data;
        logic [7:0]        pa_data;
        logic [7:0]        pb_dir;
        logic [7:0]        pb_data;
        logic [7:0]        p2_dir;
        logic [7:0]        p4_dir;
        logic [3:0]        p5_dir;
        logic [7:0]        p2_pu;
        logic [7:0]        p4_pu;
        logic [3:0]        p5_pu;
        logic [7:0]        p2_pu_en;
        logic [7:0]        p4_pu_en;
        logic [3:0]        p5_pu_en;
    } pdp_state_s;

    pdp_state_s state_reg;
    pdp_state_s state_next;
    logic [7:0] p7_level;
    logic       wr_fire;
    logic       ar_fire;
    pdp_sel_e   wr_sel;
    pdp_sel_e   rd_sel;
    logic [7:0] rd_value;

    // port 7 pins are asynchronous; read only after two flops
    pdp_sync #(
        .WIDTH (8)
    ) u_p7_sync (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .async_i   (port7_pins_i),
        .sync_o    (p7_level)
    );

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb
    begin
        rd_sel   = pdp_decode(s_axi_araddr_i);
        rd_value = RST_BYTE;
        case (rd_sel)
            SEL_P7_PINS: rd_value = p7_level;                        // see R8
            SEL_P8_DATA: rd_value = {3'h0, state_reg.p8_data};
            SEL_PA_DATA: rd_value = state_reg.pa_data;               // see R3
            SEL_PB_DATA: rd_value = state_reg.pb_data;               // see R2
            SEL_P2_PU:   rd_value = state_reg.p2_pu;
            SEL_P4_PU:   rd_value = state_reg.p4_pu;                 // see R4
            SEL_P5_PU:   rd_value = {4'h0, state_reg.p5_pu};
            // direction registers are write-only and read as zero
            default:     rd_value = RST_BYTE;
        endcase
    end

    // ------------------------------------------------------------
    // bus slave and register updates
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        wr_sel     = pdp_decode(state_reg.aw_addr);
        wr_fire    = state_reg.aw_full && state_reg.w_full && !state_reg.bvalid;
        ar_fire    = s_axi_arvalid_i && state_reg.arready;

        if (s_axi_awvalid_i && state_reg.awready)
        begin
            state_next.aw_full = 1'b1;
            state_next.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && state_reg.wready)
        begin
            state_next.w_full = 1'b1;
            state_next.w_byte = s_axi_wdata_i[7:0];
            // registers live in byte lane 0 only
            state_next.w_en   = s_axi_wstrb_i[0];
        end

        if (wr_fire)
        begin
            state_next.aw_full = 1'b0;
            state_next.w_full  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            if (state_reg.w_en)
            begin
                case (wr_sel)
                    SEL_P8_DIR:  state_next.p8_dir  = state_reg.w_byte[4:0];
                    SEL_P8_DATA: state_next.p8_data = state_reg.w_byte[4:0];
                    SEL_P2_DIR:  state_next.p2_dir  = state_reg.w_byte;
                    SEL_P4_DIR:  state_next.p4_dir  = state_reg.w_byte;
                    SEL_P5_DIR:  state_next.p5_dir  = state_reg.w_byte[3:0];
                    SEL_PA_DATA: state_next.pa_data = state_reg.w_byte;  // see R3
                    SEL_PB_DIR:  state_next.pb_dir  = state_reg.w_byte;  // see R1
                    SEL_PB_DATA: state_next.pb_data = state_reg.w_byte;  // see R2
                    SEL_P2_PU:   state_next.p2_pu   = state_reg.w_byte;
                    SEL_P4_PU:   state_next.p4_pu   = state_reg.w_byte;  // see R4
                    SEL_P5_PU:   state_next.p5_pu   = state_reg.w_byte[3:0];
                    // pin levels of port 7 cannot be written
                    default:     state_next.pb_data = state_reg.pb_data; // see R8
                endcase
            end
        end
        else if (state_reg.bvalid && s_axi_bready_i)
        begin
            state_next.bvalid = 1'b0;
        end

        // one write in flight: hold off new channels until the response is taken
        state_next.awready = !state_next.aw_full && !state_next.bvalid;
        state_next.wready  = !state_next.w_full && !state_next.bvalid;

        if (ar_fire)
        begin
            state_next.rvalid = 1'b1;
            state_next.rdata  = rd_value;
            state_next.rresp  = (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        else if (state_reg.rvalid && s_axi_rready_i)
        begin
            state_next.rvalid = 1'b0;
        end
        state_next.arready = !state_next.rvalid;

        // pull-ups only on input pins; derived from next values so enables stay aligned
        state_next.p2_pu_en = state_next.p2_pu & ~state_next.p2_dir;  // see R6
        state_next.p4_pu_en = state_next.p4_pu & ~state_next.p4_dir;  // see R5
        state_next.p5_pu_en = state_next.p5_pu & ~state_next.p5_dir;  // see R7
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            state_reg         <= '0;
            state_reg.bresp   <= RESP_OKAY;
            state_reg.rresp   <= RESP_OKAY;
            state_reg.p8_dir  <= RST_PORT8;
            state_reg.p8_data <= RST_PORT8;
            state_reg.pa_data <= RST_BYTE;                            // see R3
            state_reg.pb_dir  <= RST_BYTE;                            // see R1
            state_reg.pb_data <= RST_BYTE;                            // see R2
            state_reg.p4_pu   <= RST_BYTE;                            // see R4
            state_reg.p5_dir  <= RST_PORT5;
            state_reg.p5_pu   <= RST_PORT5;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready_o = state_reg.awready;
    assign s_axi_wready_o  = state_reg.wready;
    assign s_axi_bvalid_o  = state_reg.bvalid;
    assign s_axi_bresp_o   = state_reg.bresp;
    assign s_axi_arready_o = state_reg.arready;
    assign s_axi_rvalid_o  = state_reg.rvalid;
    assign s_axi_rresp_o   = state_reg.rresp;
    assign s_axi_rdata_o   = {24'h00_0000, state_reg.rdata};
    assign porta_data_o    = state_reg.pa_data;
    assign portb_data_o    = state_reg.pb_data;
    assign portb_oe_o      = state_reg.pb_dir;
    assign port8_data_o    = state_reg.p8_data;
    assign port8_oe_o      = state_reg.p8_dir;
    assign port2_oe_o      = state_reg.p2_dir;
    assign port4_oe_o      = state_reg.p4_dir;
    assign port5_oe_o      = state_reg.p5_dir;
    assign port2_pullup_o  = state_reg.p2_pu_en;
    assign port4_pullup_o  = state_reg.p4_pu_en;
    assign port5_pullup_o  = state_reg.p5_pu_en;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    AST_PB_DIR_WRITE: assert property ( // see R1
        wr_fire && state_reg.w_en && wr_sel == SEL_PB_DIR
        |=> portb_oe_o == $past(state_reg.w_byte) && s_axi_bvalid_o)
        else $error("port b direction did not take written value");

    AST_PB_DATA_READ: assert property ( // see R2
        ar_fire && rd_sel == SEL_PB_DATA
        |=> s_axi_rvalid_o && s_axi_rdata_o[7:0] == $past(portb_data_o))
        else $error("port b data read mismatch");

    AST_PA_DATA_WRITE: assert property ( // see R3
        wr_fire && state_reg.w_en && wr_sel == SEL_PA_DATA
        |=> porta_data_o == $past(state_reg.w_byte))
        else $error("port a data did not take written value");

    AST_P4_PU_FOLLOW: assert property ( // see R4
        port4_pullup_o == (state_reg.p4_pu & ~port4_oe_o))
        else $error("port 4 pull-up enable does not follow control");

    AST_P4_PU_INPUT_ONLY: assert property ( // see R5
        (port4_pullup_o & port4_oe_o) == 8'h00)
        else $error("port 4 pull-up active on output pin");

    AST_P2_PU_INPUT_ONLY: assert property ( // see R6
        (port2_pullup_o & port2_oe_o) == 8'h00 && port2_pullup_o == (state_reg.p2_pu & ~port2_oe_o))
        else $error("port 2 pull-up active on output pin");

    AST_P5_PU_INPUT_ONLY: assert property ( // see R7
        (port5_pullup_o & port5_oe_o) == 4'h0 && port5_pullup_o == (state_reg.p5_pu & ~port5_oe_o))
        else $error("port 5 pull-up active on output pin");

    AST_P7_READ_PINS: assert property ( // see R8
        ar_fire && rd_sel == SEL_P7_PINS
        |=> s_axi_rvalid_o && s_axi_rdata_o[7:0] == $past(p7_level))
        else $error("port 7 read does not return pin levels");

    AST_WRITE_RESP_HELD: assert property (
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped before handshake");

    AST_PB_DATA_WRITE: assert property ( // see R2
        wr_fire && state_reg.w_en && wr_sel == SEL_PB_DATA
        |=> portb_data_o == $past(state_reg.w_byte) && s_axi_bvalid_o)
        else $error("port b data did not take written value");

    AST_PB_DIR_READS_ZERO: assert property ( // see R1
        ar_fire && rd_sel == SEL_PB_DIR
        |=> s_axi_rvalid_o && s_axi_rdata_o == 32'h0000_0000 && s_axi_rresp_o == RESP_OKAY)
        else $error("write-only direction register did not read as zero");

    // a cleared lane-0 strobe must leave port A data, port B data and port B direction alone
    AST_NO_STROBE_KEEPS: assert property ( // see R3
        wr_fire && !state_reg.w_en
        |=> $stable(porta_data_o) && $stable(portb_data_o) && $stable(portb_oe_o))
        else $error("write without lane 0 strobe changed a register");

    AST_P7_WRITE_IGNORED: assert property ( // see R8
        wr_fire && wr_sel == SEL_P7_PINS
        |=> $stable({porta_data_o, portb_data_o, portb_oe_o, port4_pullup_o, port8_data_o, port8_oe_o})
            && s_axi_bresp_o == RESP_OKAY)
        else $error("write to port 7 pin levels changed state");

    AST_UNMAPPED_READ: assert property (
        ar_fire && rd_sel == SEL_NONE
        |=> s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0000_0000)
        else $error("unmapped read did not answer slave error with zero data");

    COV_WRITE_DONE:  cover property (s_axi_bvalid_o && s_axi_bready_i);
    COV_P7_READ:     cover property (ar_fire && rd_sel == SEL_P7_PINS);
    COV_READ_DONE:   cover property (s_axi_rvalid_o && s_axi_rready_i);
    COV_P4_PULLUP:   cover property (port4_pullup_o != 8'h00);
    COV_UNMAPPED:    cover property (s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR);

endmodule

// [pdp_pins.sv]
// model of the external pins: drives the port 7 input-only pins
module pdp_pins
(
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] level_i,
    output logic      [7:0] port7_pins_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // pins move just after an edge, like real pads settling between samples
    always @(posedge clk_sys_i)
    begin
        port7_pins_o <= #2 level_i;
    end
endmodule

// [pdp_regs_test.sv]
// self-checking testbench for the port direction, data and pull-up register set
module pdp_regs_test;
    import pdp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct { logic [9:0] idx; logic [7:0] wr; logic [7:0] rd; } pdp_row_s;

    logic              clk_sys_i = 1'b0;
    logic              rst_n_i   = 1'b0;
    logic [ADDR_W-1:0] awaddr    = '0;
    logic              awvalid   = 1'b0;
    logic              awready;
    logic [31:0]       wdata     = '0;
    logic [3:0]        wstrb     = 4'h0;
    logic              wvalid    = 1'b0;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              bready    = 1'b0;
    logic [ADDR_W-1:0] araddr    = '0;
    logic              arvalid   = 1'b0;
    logic              arready;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              rvalid;
    logic              rready    = 1'b0;
    logic [7:0]        pin_level = 8'h3c;
    logic [7:0]        p7_pins;
    logic [7:0]        pa_d, pb_d, pb_oe, p2_oe, p4_oe, p2_pu, p4_pu;
    logic [4:0]        p8_d, p8_oe;
    logic [3:0]        p5_oe, p5_pu;
    logic [1:0]        resp;
    logic [31:0]       data;
    int                fails       = 0;
    int                checks_done = 0;
    pdp_row_s          rows [7];

    initial
    begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    pdp_pins pins_u (.clk_sys_i(clk_sys_i), .level_i(pin_level), .port7_pins_o(p7_pins));

    pdp_regs dut_u (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .port7_pins_i(p7_pins), .porta_data_o(pa_d), .portb_data_o(pb_d), .portb_oe_o(pb_oe),
        .port8_data_o(p8_d), .port8_oe_o(p8_oe), .port2_oe_o(p2_oe), .port4_oe_o(p4_oe),
        .port5_oe_o(p5_oe), .port2_pullup_o(p2_pu), .port4_pullup_o(p4_pu), .port5_pullup_o(p5_pu)
    );

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // handshakes are judged on values sampled at the falling edge, so no race with the edge itself
    task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [3:0] strb, output logic [1:0] r);
        logic aw_hs, w_hs, b_hs;
        int   n;
        @(posedge clk_sys_i);
        awaddr  <= {idx, 2'b00};
        awvalid <= 1'b1;
        wdata   <= {24'h00_0000, d};
        wstrb   <= strb;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(negedge clk_sys_i);
            aw_hs = awvalid && awready;
            w_hs  = wvalid && wready;
            b_hs  = bvalid;
            r     = bresp;
            @(posedge clk_sys_i);
            if (aw_hs)
                awvalid <= 1'b0;
            if (w_hs)
                wvalid <= 1'b0;
            if (b_hs)
                break;
        end
        bready <= 1'b0;
        if (n == 50)
        begin
            chk("write timeout", 1, 0);
            give_verdict();
        end
    endtask

    task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
        logic ar_hs, r_hs;
        int   n;
        @(posedge clk_sys_i);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(negedge clk_sys_i);
            ar_hs = arvalid && arready;
            r_hs  = rvalid;
            d     = rdata;
            r     = rresp;
            @(posedge clk_sys_i);
            if (ar_hs)
                arvalid <= 1'b0;
            if (r_hs)
                break;
        end
        rready <= 1'b0;
        if (n == 50)
        begin
            chk("read timeout", 1, 0);
            give_verdict();
        end
    endtask

    initial
    begin
        rows[0] = '{IDX_PORTB_OUTPUT_DATA,    8'ha5, 8'ha5};
        rows[1] = '{IDX_PORTA_OUTPUT_DATA,    8'h5a, 8'h5a};
        rows[2] = '{IDX_PORT4_PULLUP_CONTROL, 8'hc3, 8'hc3};
        rows[3] = '{IDX_PORTB_DIRECTION,      8'h0f, 8'h00};
        rows[4] = '{IDX_PORT7_PIN_LEVELS,     8'hff, 8'h3c};
        rows[5] = '{IDX_PORT8_DIRECTION,      8'h1f, 8'h00};
        rows[6] = '{IDX_PORT8_OUTPUT_DATA,    8'hf5, 8'h15};
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(negedge clk_sys_i);
        chk("outputs after reset", {pa_d, pb_d, pb_oe, p4_pu}, 32'h0000_0000);
        chk("dirs after reset", {p2_oe, p4_oe, 4'h0, p5_oe, 3'h0, p8_oe}, 32'h0000_0000);
        rd(IDX_PORTB_OUTPUT_DATA, data, resp);
        chk("portb data reset", data, 32'h0000_0000);
        rd(IDX_PORT4_PULLUP_CONTROL, data, resp);
        chk("port4 pullup reset", data, 32'h0000_0000);
        // -------------------------------------------------
        // ordinary cases: write then read back
        // -------------------------------------------------
        foreach (rows[i])
        begin
            wr(rows[i].idx, rows[i].wr, 4'h1, resp);
            chk("write resp", resp, RESP_OKAY);
            rd(rows[i].idx, data, resp);
            chk("read back", data, {24'h00_0000, rows[i].rd});
        end
        @(negedge clk_sys_i);
        chk("port outputs", {pb_d, pa_d, pb_oe, p4_pu}, 32'ha55a_0fc3);
        chk("port8 outputs", {p8_oe, p8_d}, 32'h0000_03f5);
        // -------------------------------------------------
        // pull-ups only act on inputs
        // -------------------------------------------------
        wr(IDX_PORT4_DIRECTION, 8'h0f, 4'h1, resp);
        wr(IDX_PORT2_PULLUP_CONTROL, 8'hff, 4'h1, resp);
        wr(IDX_PORT2_DIRECTION, 8'h81, 4'h1, resp);
        wr(IDX_PORT5_PULLUP_CONTROL, 8'h0f, 4'h1, resp);
        wr(IDX_PORT5_DIRECTION, 8'h05, 4'h1, resp);
        @(negedge clk_sys_i);
        chk("port4 pullup", p4_pu, 32'h0000_00c0);
        chk("port2 pullup", p2_pu, 32'h0000_007e);
        chk("port5 pullup", p5_pu, 32'h0000_000a);
        chk("port dirs", {p2_oe, p4_oe, 4'h0, p5_oe, 3'h0, p8_oe}, 32'h810f_051f);
        // -------------------------------------------------
        // awkward cases
        // -------------------------------------------------
        @(posedge clk_sys_i);
        pin_level <= 8'hc3;
        repeat (4) @(posedge clk_sys_i);
        rd(IDX_PORT7_PIN_LEVELS, data, resp);
        chk("port7 live pins", data, 32'h0000_00c3);
        wr(IDX_PORTA_OUTPUT_DATA, 8'hff, 4'h0, resp);
        rd(IDX_PORTA_OUTPUT_DATA, data, resp);
        chk("porta unstrobed write", data, 32'h0000_005a);
        rd(10'h000, data, resp);
        chk("unmapped resp", resp, RESP_SLVERR);
        chk("unmapped data", data, 32'h0000_0000);
        // second reset in mid-run clears every register
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(negedge clk_sys_i);
        chk("outputs mid reset", {pa_d, pb_d, pb_oe, p4_pu}, 32'h0000_0000);
        chk("dirs mid reset", {p2_oe, p4_oe, 4'h0, p5_oe, 3'h0, p8_oe}, 32'h0000_0000);
        chk("pullups mid reset", {p2_pu, 4'h0, p5_pu, 3'h0, p8_d, 8'h00}, 32'h0000_0000);
        rd(IDX_PORTA_OUTPUT_DATA, data, resp);
        chk("porta after reset", data, 32'h0000_0000);
        give_verdict();
    end
endmodule
